// >>> include/mhc_regs.vh
`ifndef MHC_REGS_VH
`define MHC_REGS_VH
// ----------------------------------------
// register addresses (7-bit word address)
// ----------------------------------------
`define MHC_ADDR_MODE_SUPPLY 7'h01
`define MHC_ADDR_HW_CONTROL 7'h02
// ----------------------------------------
// mode/supply fields
// ----------------------------------------
`define MHC_MODE_HI 15
`define MHC_MODE_LO 14
`define MHC_MODE_NORMAL 2'h0
`define MHC_MODE_SLEEP 2'h1
`define MHC_MODE_STOP 2'h2
`define MHC_MODE_SOFTRST 2'h3
`define MHC_MS_WMASK 16'hc6a3
`define MHC_MS_POR 16'h0000
`define MHC_MS_RESTART_KEEP 16'h00a3
// ----------------------------------------
// hardware_control fields
// ----------------------------------------
`define MHC_HW_WAIT_BIT 12
`define MHC_HW_OV_BIT 11
`define MHC_HW_SH_BIT 10
`define MHC_HW_RDEL_BIT 9
`define MHC_HW_SRPIN_BIT 6
`define MHC_HW_WDHI_BIT 2
`define MHC_HW_WMASK 16'h1e44
`define MHC_HW_POR 16'h0000
`define MHC_HW_SOFT_KEEP 16'h0200
`define MHC_HW_RESTART_KEEP 16'h1240
// ----------------------------------------
// timing
// ----------------------------------------
`define MHC_CLK_NS 10
`define MHC_RD_LONG_MS 10
`define MHC_RD_SHORT_MS 2
`define MHC_SOFT_PULSE_CYC 5'h10
`endif

// >>> core/mhc_reset_timer.v
`timescale 1ns/10ps
// ----------------------------------------
// reset output release timer
// ----------------------------------------
module mhc_reset_timer #(
    parameter LONG_CYC = 1000000,
    parameter SHORT_CYC = 200000
) (
    clk,
    reset,
    clk_en,
    start,
    short_sel,
    busy
);
    input wire clk;
    input wire reset;
    input wire clk_en;
    input wire start;
    input wire short_sel;
    output reg busy;

    reg [20:0] cnt_q;

    always @(posedge clk) begin
        if (reset) begin
            cnt_q <= 21'h000000;
            busy <= 1'b0;
        end else if (clk_en) begin
            if (start) begin
                cnt_q <= short_sel ? SHORT_CYC[20:0] : LONG_CYC[20:0];
                busy <= 1'b1;
            end else if (cnt_q != 21'h000000) begin
                cnt_q <= cnt_q - 21'h000001;
                busy <= (cnt_q != 21'h000001);
            end else begin
                busy <= 1'b0;
            end
        end
    end
endmodule

// >>> core/mhc_ctrl_regs.v
`timescale 1ns/10ps
`include "mhc_regs.vh"
// Contract
// - stop to sleep mode change is ignored; the other fields of the write land
// - restart entry loads mode normal
// - write returns previously programmed value
// - mode/supply clears; restart keeps 7,5,1,0
// - bit12 selects long release wait growth
// - bit11 selects overvoltage threshold
// - bit10 high turns sample-hold off
// - bit9 selects 2 or 10 ms
// - bit6 low pulls reset_out_n on softreset
// - bit2 disables watchdog in stop
// - stop to normal clears bit2
// - reserved bits read zero, ignore writes
// - por clears; softreset keeps bit9 only
// - restart keeps bits 12,9,6
// - mode 00 normal,01 sleep,10 stop,11 reset
module mhc_ctrl_regs #(
    parameter RD_LONG_CYC = `MHC_RD_LONG_MS * 1000000 / `MHC_CLK_NS,
    parameter RD_SHORT_CYC = `MHC_RD_SHORT_MS * 1000000 / `MHC_CLK_NS
) (
    clk,
    reset,
    clk_en,
    wr_en,
    rd_en,
    addr,
    wdata,
    rdata,
    restart_evt,
    wdog_set_hi,
    mode,
    overtemp_release_wait_sel,
    supply_overvoltage_threshold_sel,
    sample_hold_off,
    reset_out_delay_sel,
    wdog_stop_disable_hi,
    reset_out_n,
    soft_reset_pulse
);
    input wire clk;
    input wire reset;
    input wire clk_en;
    input wire wr_en;
    input wire rd_en;
    input wire [6:0] addr;
    input wire [15:0] wdata;
    output reg [15:0] rdata;
    input wire restart_evt;
    input wire wdog_set_hi;
    output reg [1:0] mode;
    output reg overtemp_release_wait_sel;
    output reg supply_overvoltage_threshold_sel;
    output reg sample_hold_off;
    output reg reset_out_delay_sel;
    output reg wdog_stop_disable_hi;
    output reg reset_out_n;
    output reg soft_reset_pulse;

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [15:0] ms_q;
    reg [15:0] ms_d;
    reg [15:0] hw_q;
    reg [15:0] hw_d;
    reg soft_q;
    reg [4:0] pulse_cnt_q;
    reg restart_q;
    reg rd_start_q;
    reg [15:0] rd_mux;
    wire rd_busy;
    wire [1:0] cur_mode;
    wire [1:0] new_mode;
    wire wr_ms;
    wire wr_hw;

    assign cur_mode = ms_q[`MHC_MODE_HI:`MHC_MODE_LO];
    assign new_mode = wdata[`MHC_MODE_HI:`MHC_MODE_LO];
    assign wr_ms = wr_en && (addr == `MHC_ADDR_MODE_SUPPLY);
    assign wr_hw = wr_en && (addr == `MHC_ADDR_HW_CONTROL);

    // ----------------------------------------
    // next register values
    // ----------------------------------------
    always @* begin
        ms_d = ms_q;
        hw_d = hw_q;
        if (soft_q) begin
            ms_d = `MHC_MS_POR;
            hw_d = hw_q & `MHC_HW_SOFT_KEEP;
        end else if (restart_evt) begin
            ms_d = ms_q & `MHC_MS_RESTART_KEEP;
            ms_d[`MHC_MODE_HI:`MHC_MODE_LO] = `MHC_MODE_NORMAL;
            hw_d = hw_q & `MHC_HW_RESTART_KEEP;
        end else begin
            if (wr_ms) begin
                ms_d = wdata & `MHC_MS_WMASK;
                if (cur_mode == `MHC_MODE_STOP && new_mode == `MHC_MODE_SLEEP) begin
                    ms_d[`MHC_MODE_HI:`MHC_MODE_LO] = cur_mode;
                end
                // the soft reset code never lands in the mode field
                if (new_mode == `MHC_MODE_SOFTRST) begin
                    ms_d[`MHC_MODE_HI:`MHC_MODE_LO] = cur_mode;
                end
                if (cur_mode == `MHC_MODE_STOP && new_mode == `MHC_MODE_NORMAL) begin
                    hw_d[`MHC_HW_WDHI_BIT] = 1'b0;
                end
            end
            if (wr_hw) begin
                hw_d = wdata & `MHC_HW_WMASK;
            end
            if (wdog_set_hi) begin
                hw_d[`MHC_HW_WDHI_BIT] = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // register state
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            ms_q <= `MHC_MS_POR;
            hw_q <= `MHC_HW_POR;
        end else if (clk_en) begin
            ms_q <= ms_d;
            hw_q <= hw_d;
        end
    end

    // ----------------------------------------
    // soft reset and restart sequencing
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            soft_q <= 1'b0;
            restart_q <= 1'b0;
            rd_start_q <= 1'b0;
            pulse_cnt_q <= 5'h00;
            soft_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            // mode 11 is not stored: it fires one soft reset
            soft_q <= wr_ms && !soft_q && !restart_evt
                && (new_mode == `MHC_MODE_SOFTRST);
            soft_reset_pulse <= soft_q;
            restart_q <= restart_evt;
            // reset_out_n only pulled on soft reset when bit6 was low
            rd_start_q <= (soft_q && !hw_q[`MHC_HW_SRPIN_BIT]) || restart_evt;
            if (soft_q && !hw_q[`MHC_HW_SRPIN_BIT]) begin
                pulse_cnt_q <= `MHC_SOFT_PULSE_CYC;
            end else if (pulse_cnt_q != 5'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 5'h01;
            end
        end
    end

    // ----------------------------------------
    // read select
    // ----------------------------------------
    always @* begin
        case (addr)
            `MHC_ADDR_MODE_SUPPLY: rd_mux = ms_q & `MHC_MS_WMASK;
            `MHC_ADDR_HW_CONTROL: rd_mux = hw_q & `MHC_HW_WMASK;
            default: rd_mux = 16'h0000;
        endcase
    end

    // ----------------------------------------
    // read-back
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            rdata <= 16'h0000;
        end else if (clk_en) begin
            // old value is captured before the write lands
            if (rd_en || wr_en) begin
                rdata <= rd_mux;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            mode <= `MHC_MODE_NORMAL;
            overtemp_release_wait_sel <= 1'b0;
            supply_overvoltage_threshold_sel <= 1'b0;
            sample_hold_off <= 1'b0;
            reset_out_delay_sel <= 1'b0;
            wdog_stop_disable_hi <= 1'b0;
        end else if (clk_en) begin
            mode <= ms_q[`MHC_MODE_HI:`MHC_MODE_LO];
            overtemp_release_wait_sel <= hw_q[`MHC_HW_WAIT_BIT];
            supply_overvoltage_threshold_sel <= hw_q[`MHC_HW_OV_BIT];
            sample_hold_off <= hw_q[`MHC_HW_SH_BIT];
            reset_out_delay_sel <= hw_q[`MHC_HW_RDEL_BIT];
            wdog_stop_disable_hi <= hw_q[`MHC_HW_WDHI_BIT];
        end
    end

    // ----------------------------------------
    // reset output
    // ----------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            reset_out_n <= 1'b0;
        end else if (clk_en) begin
            // held low while the release delay or the soft pulse runs
            reset_out_n <= !(rd_busy || rd_start_q || pulse_cnt_q != 5'h00);
        end
    end

    mhc_reset_timer #(
        .LONG_CYC(RD_LONG_CYC),
        .SHORT_CYC(RD_SHORT_CYC)
    ) u_rtimer (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .start(rd_start_q || restart_q),
        .short_sel(hw_q[`MHC_HW_RDEL_BIT]),
        .busy(rd_busy)
    );
endmodule

// >>> dv/mhc_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// register host on the far side
// ----------------------------------------
module mhc_host_model(input wire clk, output logic wr_en, output logic rd_en,
    output logic [6:0] addr, output logic [15:0] wdata);
    initial begin
        wr_en = 0;
        rd_en = 0;
        addr = 0;
        wdata = 0;
    end
    // strobe stays up across calls, so two calls give back-to-back requests
    task acc(input bit w, input [6:0] a, input [15:0] d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wdata <= d;
    endtask
    // released lines invert so a stale sample shows up
    task idle;
        @(posedge clk);
        wr_en <= 0;
        rd_en <= 0;
        addr <= ~addr;
        wdata <= ~wdata;
    endtask
endmodule

// >>> dv/mhc_ctrl_regs_props.sv
`timescale 1ns/10ps
module mhc_ctrl_regs_props(input wire clk, input wire reset, input wire wr_en, input wire rd_en,
    input wire [6:0] addr, input wire [15:0] wdata, input wire [15:0] rdata,
    input wire restart_evt, input wire wdog_set_hi, input wire [1:0] mode,
    input wire overtemp_release_wait_sel, input wire supply_overvoltage_threshold_sel,
    input wire sample_hold_off, input wire reset_out_delay_sel,
    input wire wdog_stop_disable_hi, input wire soft_reset_pulse);
    wire w1 = wr_en && addr == 7'h01;
    wire w2 = wr_en && addr == 7'h02;
    wire s1 = w1 && wdata[15:14] == 2'h3;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_sleep_refused: assert property (w1 && wdata[15:14] == 2'h1 && mode == 2'h2
        && !$past(wr_en) && !restart_evt && !$past(restart_evt) && !soft_reset_pulse
        |-> ##2 mode == 2'h2) else $error("left stop");
    a_restart_normal: assert property (restart_evt ##1 !wr_en |=> mode == 2'h0)
        else $error("restart mode");
    a_prev_value: assert property (w2 && !wdog_set_hi && !restart_evt && !$past(s1) ##1 w2
        |=> rdata == ($past(wdata, 2) & 16'h1e44)) else $error("read-back");
    a_fields_follow: assert property (w2 && !restart_evt && !$past(s1)
        ##1 !restart_evt && !w2
        |=> {3'h0, overtemp_release_wait_sel, supply_overvoltage_threshold_sel,
        sample_hold_off, reset_out_delay_sel, 9'h0} == ($past(wdata, 2) & 16'h1e00))
        else $error("fields");
    a_soft_clear: assert property (soft_reset_pulse |=> mode == 2'h0 &&
        !overtemp_release_wait_sel && !supply_overvoltage_threshold_sel && !sample_hold_off
        && !wdog_stop_disable_hi && $stable(reset_out_delay_sel)) else $error("soft clear");
    a_wdog_set: assert property (wdog_set_hi && !restart_evt ##1 !soft_reset_pulse
        |=> wdog_stop_disable_hi) else $error("wdog set");
    a_stop_exit: assert property (w1 && wdata[15:14] == 2'h0 && mode == 2'h2
        && !$past(wr_en) && !wdog_set_hi |=> ##1 !wdog_stop_disable_hi) else $error("stop exit");
    a_rsvd_zero: assert property ((rd_en || wr_en) && addr == 7'h02
        |=> (rdata & 16'he1bb) == 16'h0) else $error("reserved");
    a_soft_cause: assert property (s1 && !restart_evt && !$past(s1)
        |-> ##2 soft_reset_pulse) else $error("soft missing");
endmodule
bind mhc_ctrl_regs mhc_ctrl_regs_props i_props(.*);

// >>> dv/mhc_ctrl_regs_bench.sv
`timescale 1ns/10ps
`include "mhc_regs.vh"
module mhc_ctrl_regs_bench;
    logic clk = 0, reset = 1, restart_evt = 0, wdog_set_hi = 0, wr_en, rd_en;
    logic [6:0] addr;
    logic [15:0] wdata, rdata, r;
    logic [1:0] mode;
    logic ow, ov, sh, rd, wd, ro_n, sp;
    int miscompares = 0, n_compared = 0, cyc = 0, seed = 32'h5d5a7ad0, i;
    mhc_host_model h(.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata));
    // short release counts keep the run brief
    mhc_ctrl_regs #(.RD_LONG_CYC(20), .RD_SHORT_CYC(4)) i_mhc_ctrl_regs(.clk(clk),
        .reset(reset), .clk_en(1'b1), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .restart_evt(restart_evt), .wdog_set_hi(wdog_set_hi),
        .mode(mode), .overtemp_release_wait_sel(ow), .supply_overvoltage_threshold_sel(ov),
        .sample_hold_off(sh), .reset_out_delay_sel(rd), .wdog_stop_disable_hi(wd),
        .reset_out_n(ro_n), .soft_reset_pulse(sp));
    initial forever #5 clk = ~clk;
    function [15:0] hw_exp(input [15:0] d);
        hw_exp = d & `MHC_HW_WMASK;
    endfunction
    task complete_run;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string n, input [15:0] s, input [15:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [6:0] a, input [15:0] d);
        h.acc(1, a, d);
        h.idle;
    endtask
    task rdc(input [6:0] a, input [15:0] e);
        h.acc(0, a, 16'h0);
        h.idle;
        #1 chk("rdata", rdata, e);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 0;
        rdc(7'h02, 16'h0);
        rdc(7'h01, 16'h0);
        rdc(7'h7f, 16'h0);
        @(posedge clk) restart_evt <= 1;
        @(posedge clk) restart_evt <= 0;
        for (i = 0; i < 8; i++) begin
            r = (i == 0) ? 16'hffff : $random(seed);
            h.acc(1, 7'h02, r);
            h.acc(1, 7'h02, ~r);
            h.idle;
            #1 chk("rdata", rdata, hw_exp(r));
            @(posedge clk) #1 chk("fields", {3'h0, ow, ov, sh, rd, 9'h0}, ~r & 16'h1e00);
        end
        for (i = 0; i < 2; i++) begin
            wr(7'h02, 16'h1200 | (i << 6));
            repeat (60) @(posedge clk);
            wr(7'h01, 16'hc000);
            @(posedge clk) #1 chk("soft_pulse", sp, 16'h0001);
            repeat (2) @(posedge clk);
            #1 chk("reset_out_n", ro_n, i[0]);
            rdc(7'h02, 16'h0200);
            rdc(7'h01, 16'h0);
        end
        wr(7'h02, 16'hffff);
        wr(7'h01, 16'h86a3);
        @(posedge clk) restart_evt <= 1;
        @(posedge clk) restart_evt <= 0;
        rdc(7'h01, 16'h00a3);
        rdc(7'h02, 16'h1240);
        wr(7'h01, 16'h4000);
        @(posedge clk) #1 chk("mode", mode, 2'h1);
        wr(7'h01, 16'h8000);
        wr(7'h01, 16'h4000);
        rdc(7'h01, 16'h8000);
        @(posedge clk) wdog_set_hi <= 1;
        @(posedge clk) wdog_set_hi <= 0;
        rdc(7'h02, 16'h1244);
        chk("wdog", wd, 16'h0001);
        wr(7'h01, 16'h0000);
        rdc(7'h02, 16'h1240);
        chk("wdog", wd, 16'h0000);
        complete_run;
    end
endmodule
